// *** rtl/fslc_host.sv ***
// Summary of operation
// - Bits 6..0 are only evaluated after bit 7 reads one.
// - Host masks reserved bit 0 of every polled status byte.
// - Host issues clear status after any error before anything else.
// - Lock set is two writes: 60h, then 01h block or f1h master.
// - Host writes ffh after last lock set to return to array.
// - Host may repeat lock sets and check status each time.
// - Check supply, protect, both 4 and 5, then 4, then 5.
// - Protect flag matters only where lock configuration is used.
module fslc_host (
   input  wire logic                           CORE_CLK,        // Core clock
   input  wire logic                           RESETN,          // Async reset, low
   input  wire logic                           HSEL,            // Slave select
   input  wire logic [31:0]                    HADDR,           // Byte address
   input  wire logic [1:0]                     HTRANS,          // Transfer type
   input  wire logic                           HWRITE,          // Write flag
   input  wire logic [2:0]                     HSIZE,           // Transfer size
   input  wire logic [31:0]                    HWDATA,          // Write data
   input  wire logic                           HREADY,          // Bus ready
   output logic      [31:0]                    HRDATA,          // Read data
   output logic                                HREADYOUT,       // Slave ready
   output logic                                HRESP,           // Always OKAY
   output logic      [fslc_pkg::FL_ADDR_W-1:0] FL_ADDR,         // Flash address
   input  wire logic [7:0]                     FL_DQ_IN,        // Flash data in
   output logic      [7:0]                     FL_DQ_OUT,       // Flash data out
   output logic                                FL_DQ_OE_N,      // Low while driving
   output logic                                FL_CE_N,         // Chip enable
   output logic                                FL_OE_N,         // Output enable
   output logic                                FL_WE_N,         // Write enable
   output logic                                RESET_POWERDOWN_N_PIN, // Device reset
   input  wire logic                           READY_BUSY_N_PIN // Low while busy
);

   typedef enum {S_IDLE, S_WR_STROBE, S_WR_RECOVER, S_WAIT_READY,
                 S_RD_ACCESS, S_EVAL, S_DONE} fslc_state_e;
   typedef enum {PH_SETUP, PH_CONFIRM, PH_CLEAR, PH_ARRAY} fslc_phase_e;

   fslc_state_e            state;
   fslc_state_e            next_state;
   fslc_phase_e            phase;
   fslc_phase_e            next_phase;
   logic [3:0]             cnt;
   logic [3:0]             next_cnt;
   fslc_pkg::fslc_flash_s  bus;
   fslc_pkg::fslc_flash_s  next_bus;
   fslc_pkg::fslc_byte_t   status_byte;
   fslc_pkg::fslc_byte_t   next_status_byte;
   fslc_pkg::fslc_result_e result;
   fslc_pkg::fslc_result_e next_result;
   logic                   done;
   logic                   next_done;
   logic                   op_master;
   logic                   master_sel;
   logic                   clr_err_en;
   logic                   array_en;
   logic                   rp_n;
   logic [fslc_pkg::FL_ADDR_W-1:0] target_addr;
   logic                   ryby_meta;
   logic                   ryby_sync;
   logic [7:0]             dq_meta;
   logic [7:0]             dq_sync;
   logic                   wr_pend;
   logic                   rd_pend;
   logic [7:0]             bus_ofs;
   logic                   hreadyout;
   logic [31:0]            hrdata;

   // Build one write or read cycle on the flash pins
   function automatic fslc_pkg::fslc_flash_s write_cycle(
      input logic [fslc_pkg::FL_ADDR_W-1:0] a, input fslc_pkg::fslc_byte_t d);
      fslc_pkg::fslc_flash_s c;
      c         = fslc_pkg::FLASH_IDLE;
      c.addr    = a;
      c.dq      = d;
      c.dq_oe_n = 1'b0;
      c.ce_n    = 1'b0;
      c.we_n    = 1'b0;
      return c;
   endfunction : write_cycle

   function automatic fslc_pkg::fslc_flash_s read_cycle(
      input logic [fslc_pkg::FL_ADDR_W-1:0] a);
      fslc_pkg::fslc_flash_s c;
      c      = fslc_pkg::FLASH_IDLE;
      c.addr = a;
      c.ce_n = 1'b0;
      c.oe_n = 1'b0;
      return c;
   endfunction : read_cycle

   // Full status check; first matching error wins
   function automatic fslc_pkg::fslc_result_e eval_status(input fslc_pkg::fslc_byte_t s);
      fslc_pkg::fslc_result_e r;
      r = fslc_pkg::RES_OK;
      if (s[fslc_pkg::SB_SUPPLY])
         r = fslc_pkg::RES_SUPPLY;
      else if (s[fslc_pkg::SB_PROTECT])
         r = fslc_pkg::RES_PROTECT;
      else if (s[fslc_pkg::SB_PROG_ERR] && s[fslc_pkg::SB_ERASE_ERR])
         r = fslc_pkg::RES_SEQUENCE;
      else if (s[fslc_pkg::SB_PROG_ERR])
         r = fslc_pkg::RES_LOCKSET;
      else if (s[fslc_pkg::SB_ERASE_ERR])
         r = fslc_pkg::RES_ERASE;
      return r;
   endfunction : eval_status

   // Bus decode
   wire ahb_acc   = HSEL && HTRANS[1] && HREADY && (HSIZE == 3'h2);
   wire ctrl_wr   = wr_pend && (bus_ofs == fslc_pkg::OFS_CTRL);
   wire addr_wr   = wr_pend && (bus_ofs == fslc_pkg::OFS_ADDR);
   wire start     = ctrl_wr && HWDATA[fslc_pkg::CB_START] && (state == S_IDLE);
   wire busy      = (state != S_IDLE);
   wire fslc_pkg::fslc_result_e eval_res = eval_status(status_byte);
   wire need_clr  = (eval_res != fslc_pkg::RES_OK) && clr_err_en;
   wire [31:0] ctrl_word = {27'h0000000, rp_n, array_en, clr_err_en, master_sel, 1'b0};
   wire [31:0] addr_word = {{(32 - fslc_pkg::FL_ADDR_W){1'b0}}, target_addr};
   wire [31:0] stat_word = {16'h0000, status_byte, 1'b0, result, 1'b0, ryby_sync, done, busy};
   wire [31:0] rd_mux    = (bus_ofs == fslc_pkg::OFS_CTRL) ? ctrl_word :
                           (bus_ofs == fslc_pkg::OFS_ADDR) ? addr_word :
                           (bus_ofs == fslc_pkg::OFS_STAT) ? stat_word : 32'h00000000;

   // Pin synchronisers; data lines are slow so two stages are plenty
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ryby_meta <= 1'b0;
         ryby_sync <= 1'b0;
         dq_meta   <= 8'h00;
         dq_sync   <= 8'h00;
      end else begin
         ryby_meta <= READY_BUSY_N_PIN;
         ryby_sync <= ryby_meta;
         dq_meta   <= FL_DQ_IN;
         dq_sync   <= dq_meta;
      end
   end

   // Bus slave: writes land in data phase, reads take one wait state
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         bus_ofs   <= 8'h00;
         hreadyout <= 1'b1;
         hrdata    <= 32'h00000000;
      end else begin
         wr_pend   <= ahb_acc && HWRITE;
         rd_pend   <= ahb_acc && !HWRITE;
         hreadyout <= !(ahb_acc && !HWRITE);
         if (ahb_acc)
            bus_ofs <= HADDR[7:0];
         if (rd_pend)
            hrdata <= rd_mux;
      end
   end

   // Software settings; a start while busy is dropped
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         master_sel  <= 1'b0;
         clr_err_en  <= 1'b0;
         array_en    <= 1'b0;
         rp_n        <= fslc_pkg::RP_N_RESET;
         target_addr <= '0;
         op_master   <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            master_sel <= HWDATA[fslc_pkg::CB_MASTER];
            clr_err_en <= HWDATA[fslc_pkg::CB_CLR_ERR];
            array_en   <= HWDATA[fslc_pkg::CB_ARRAY];
            rp_n       <= HWDATA[fslc_pkg::CB_RP_N];
         end
         if (addr_wr && !busy)
            target_addr <= HWDATA[fslc_pkg::FL_ADDR_W-1:0];
         if (start)
            op_master <= HWDATA[fslc_pkg::CB_MASTER];
      end
   end

   // Sequencer: setup, confirm, poll, evaluate, optional clear and array
   always_comb begin
      next_state       = state;
      next_phase       = phase;
      next_cnt         = cnt;
      next_bus         = bus;
      next_status_byte = status_byte;
      next_result      = result;
      next_done        = done;
      unique case (state)
         S_IDLE: begin
            if (start) begin
               next_done  = 1'b0;
               next_phase = PH_SETUP;
               next_bus   = write_cycle(target_addr, fslc_pkg::CMD_LOCK_SETUP);
               next_cnt   = fslc_pkg::WE_CNT;
               next_state = S_WR_STROBE;
            end
         end
         S_WR_STROBE: begin
            if (cnt == fslc_pkg::CNT_LAST) begin
               next_bus.we_n = 1'b1;
               next_bus.ce_n = 1'b1;
               next_cnt      = fslc_pkg::WH_CNT;
               next_state    = S_WR_RECOVER;
            end else begin
               next_cnt = cnt - fslc_pkg::CNT_LAST;
            end
         end
         S_WR_RECOVER: begin
            if (cnt != fslc_pkg::CNT_LAST) begin
               next_cnt = cnt - fslc_pkg::CNT_LAST;
            end else if (phase == PH_SETUP) begin
               next_phase = PH_CONFIRM;
               next_bus   = write_cycle(target_addr, op_master ? fslc_pkg::CMD_LOCK_MASTER
                                                               : fslc_pkg::CMD_LOCK_BLOCK);
               next_cnt   = fslc_pkg::WE_CNT;
               next_state = S_WR_STROBE;
            end else if (phase == PH_CONFIRM) begin
               // Device now answers reads with status, no read command sent
               next_bus   = fslc_pkg::FLASH_IDLE;
               next_state = S_WAIT_READY;
            end else if (phase == PH_CLEAR && array_en) begin
               next_phase = PH_ARRAY;
               next_bus   = write_cycle(target_addr, fslc_pkg::CMD_READ_ARRAY);
               next_cnt   = fslc_pkg::WE_CNT;
               next_state = S_WR_STROBE;
            end else begin
               next_bus   = fslc_pkg::FLASH_IDLE;
               next_state = S_DONE;
            end
         end
         S_WAIT_READY: begin
            // Busy pin low means running; suspend keeps it high, bit 7 decides
            if (ryby_sync) begin
               next_bus   = read_cycle(target_addr);
               next_cnt   = fslc_pkg::RD_CNT;
               next_state = S_RD_ACCESS;
            end
         end
         S_RD_ACCESS: begin
            if (cnt == fslc_pkg::CNT_LAST) begin
               next_status_byte = dq_sync & fslc_pkg::STATUS_MASK;
               next_bus         = fslc_pkg::FLASH_IDLE;
               next_state       = dq_sync[fslc_pkg::SB_READY] ? S_EVAL : S_WAIT_READY;
            end else begin
               next_cnt = cnt - fslc_pkg::CNT_LAST;
            end
         end
         S_EVAL: begin
            next_result = eval_res;
            next_cnt    = fslc_pkg::WE_CNT;
            if (need_clr) begin
               next_phase = PH_CLEAR;
               next_bus   = write_cycle(target_addr, fslc_pkg::CMD_CLEAR_STATUS);
               next_state = S_WR_STROBE;
            end else if (array_en) begin
               next_phase = PH_ARRAY;
               next_bus   = write_cycle(target_addr, fslc_pkg::CMD_READ_ARRAY);
               next_state = S_WR_STROBE;
            end else begin
               next_state = S_DONE;
            end
         end
         S_DONE: begin
            next_done  = 1'b1;
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state       <= S_IDLE;
         phase       <= PH_SETUP;
         cnt         <= 4'h0;
         bus         <= fslc_pkg::FLASH_IDLE;
         status_byte <= 8'h00;
         result      <= fslc_pkg::RES_OK;
         done        <= 1'b0;
      end else begin
         state       <= next_state;
         phase       <= next_phase;
         cnt         <= next_cnt;
         bus         <= next_bus;
         status_byte <= next_status_byte;
         result      <= next_result;
         done        <= next_done;
      end
   end

   // Outputs straight from flops, HRESP tied to zero
   assign HRDATA                = hrdata;
   assign HREADYOUT             = hreadyout;
   assign HRESP                 = 1'b0;
   assign FL_ADDR               = bus.addr;
   assign FL_DQ_OUT             = bus.dq;
   assign FL_DQ_OE_N            = bus.dq_oe_n;
   assign FL_CE_N               = bus.ce_n;
   assign FL_OE_N               = bus.oe_n;
   assign FL_WE_N               = bus.we_n;
   assign RESET_POWERDOWN_N_PIN = rp_n;

   // Checks
   sequence s_setup_wr;
      $fell(bus.we_n) && (bus.dq == fslc_pkg::CMD_LOCK_SETUP);
   endsequence
   sequence s_confirm_wr;
      $fell(bus.we_n) && ((bus.dq == fslc_pkg::CMD_LOCK_BLOCK) ||
                          (bus.dq == fslc_pkg::CMD_LOCK_MASTER));
   endsequence

   property p_confirm_follows_setup;
      @(posedge CORE_CLK) disable iff (!RESETN) s_setup_wr |-> ##3 s_confirm_wr;
   endproperty
   a_confirm_follows_setup: assert property (p_confirm_follows_setup)
      else $error("confirm write did not follow setup");

   property p_confirm_code;
      @(posedge CORE_CLK) disable iff (!RESETN)
         s_confirm_wr |-> (bus.dq == (op_master ? fslc_pkg::CMD_LOCK_MASTER
                                                : fslc_pkg::CMD_LOCK_BLOCK));
   endproperty
   a_confirm_code: assert property (p_confirm_code)
      else $error("wrong confirm code");

   property p_we_width;
      @(posedge CORE_CLK) disable iff (!RESETN)
         $fell(bus.we_n) |-> (!bus.we_n && !bus.ce_n && !bus.dq_oe_n && bus.oe_n)[*2]
                             ##1 bus.we_n;
   endproperty
   a_we_width: assert property (p_we_width)
      else $error("write strobe malformed");

   property p_eval_ready;
      @(posedge CORE_CLK) disable iff (!RESETN)
         (state == S_EVAL) |-> status_byte[fslc_pkg::SB_READY] && !status_byte[fslc_pkg::SB_RSVD];
   endproperty
   a_eval_ready: assert property (p_eval_ready)
      else $error("status evaluated while busy or unmasked");

   property p_read_when_ready;
      @(posedge CORE_CLK) disable iff (!RESETN) $fell(bus.oe_n) |-> $past(ryby_sync);
   endproperty
   a_read_when_ready: assert property (p_read_when_ready)
      else $error("read started while busy pin low");

   property p_clear_after_error;
      @(posedge CORE_CLK) disable iff (!RESETN)
         (state == S_EVAL) && need_clr |=>
            $fell(bus.we_n) && (bus.dq == fslc_pkg::CMD_CLEAR_STATUS);
   endproperty
   a_clear_after_error: assert property (p_clear_after_error)
      else $error("no clear status after error");

   property p_array_last;
      @(posedge CORE_CLK) disable iff (!RESETN)
         (state == S_EVAL) && !need_clr && array_en |=>
            !bus.we_n && (bus.dq == fslc_pkg::CMD_READ_ARRAY);
   endproperty
   a_array_last: assert property (p_array_last)
      else $error("no read array after lock set");

   property p_supply_first;
      @(posedge CORE_CLK) disable iff (!RESETN)
         (state == S_EVAL) && status_byte[fslc_pkg::SB_SUPPLY] |=>
            ##1 (result == fslc_pkg::RES_SUPPLY);
   endproperty
   a_supply_first: assert property (p_supply_first)
      else $error("supply error not reported first");

   property p_read_wait;
      @(posedge CORE_CLK) disable iff (!RESETN) ahb_acc && !HWRITE |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read wait state wrong");

endmodule : fslc_host

// *** pkg/fslc_pkg.sv ***
package fslc_pkg;

   // Core clock and derived bus timing
   localparam int unsigned CLK_MHZ        = 25;
   localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
   localparam int unsigned T_WE_PULSE_NS  = 50;   // Least write strobe low time
   localparam int unsigned T_WE_HIGH_NS   = 25;   // Least strobe high time between writes
   localparam int unsigned T_READ_ACC_NS  = 95;   // Longest access time from enables
   localparam int unsigned SYNC_STAGES    = 2;
   localparam int unsigned WE_CYC   = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WH_CYC   = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RD_CYC   = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  WE_CNT   = 4'(WE_CYC);
   localparam logic [3:0]  WH_CNT   = 4'(WH_CYC);
   localparam logic [3:0]  RD_CNT   = 4'(RD_CYC + SYNC_STAGES);
   localparam logic [3:0]  CNT_LAST = 4'h1;

   // Flash bus geometry and command codes
   localparam int unsigned FL_ADDR_W = 21;
   typedef logic [7:0] fslc_byte_t;
   localparam fslc_byte_t CMD_LOCK_SETUP   = 8'h60;
   localparam fslc_byte_t CMD_LOCK_BLOCK   = 8'h01;
   localparam fslc_byte_t CMD_LOCK_MASTER  = 8'hf1;
   localparam fslc_byte_t CMD_CLEAR_STATUS = 8'h50;
   localparam fslc_byte_t CMD_READ_ARRAY   = 8'hff;

   // Operation status byte bit positions
   localparam int unsigned SB_READY      = 7;
   localparam int unsigned SB_ERASE_SUSP = 6;
   localparam int unsigned SB_ERASE_ERR  = 5;
   localparam int unsigned SB_PROG_ERR   = 4;
   localparam int unsigned SB_SUPPLY     = 3;
   localparam int unsigned SB_PROG_SUSP  = 2;
   localparam int unsigned SB_PROTECT    = 1;
   localparam int unsigned SB_RSVD       = 0;
   localparam fslc_byte_t  STATUS_MASK   = 8'hfe;

   // Own register map, byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;

   // Control register bits
   localparam int unsigned CB_START   = 0;
   localparam int unsigned CB_MASTER  = 1;
   localparam int unsigned CB_CLR_ERR = 2;
   localparam int unsigned CB_ARRAY   = 3;
   localparam int unsigned CB_RP_N    = 4;
   localparam logic        RP_N_RESET = 1'b1;

   typedef enum logic [2:0] {
      RES_OK, RES_SUPPLY, RES_PROTECT, RES_SEQUENCE, RES_LOCKSET, RES_ERASE
   } fslc_result_e;

   typedef struct packed {
      logic [FL_ADDR_W-1:0] addr;
      fslc_byte_t           dq;
      logic                 dq_oe_n;
      logic                 ce_n;
      logic                 oe_n;
      logic                 we_n;
   } fslc_flash_s;

   localparam fslc_flash_s FLASH_IDLE = '{addr: '0, dq: 8'h00, dq_oe_n: 1'b1,
                                          ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

endpackage : fslc_pkg

// *** sim/fslc_flash_model.sv ***
module fslc_flash_model (
   input  wire logic                           clk,       // Bench clock, paces algorithm
   input  wire logic [fslc_pkg::FL_ADDR_W-1:0] addr,      // Flash address
   input  wire logic [7:0]                     dq_w,      // Byte driven by the host
   input  wire logic                           ce_n,      // Chip enable
   input  wire logic                           oe_n,      // Output enable
   input  wire logic                           we_n,      // Write strobe
   input  wire logic [7:0]                     fail_bits, // Error bits for next completion
   input  wire logic [7:0]                     busy_len,  // Algorithm length, at least 1
   output logic      [7:0]                     dq_r,      // Data lines towards host
   output logic                                rb_n       // Ready/busy pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]                     stat = 8'h80;
   logic [7:0]                     tog = 8'h00;
   logic [7:0]                     dq_q = 8'h00;
   logic                           we_q = 1'b1;
   logic                           ce_q = 1'b1;
   logic                           setup = 1'b0;
   logic [fslc_pkg::FL_ADDR_W-1:0] a_q = '0;
   logic [fslc_pkg::FL_ADDR_W-1:0] last_addr = '0;
   int                             busy = 0;
   fslc_pkg::fslc_byte_t           log_cmd[$];
   // Commands land when the strobe closes; suspend bits 6 and 2 never set here
   always @(posedge clk) begin
      tog <= tog + 8'h5b;
      we_q <= we_n;
      ce_q <= ce_n;
      dq_q <= dq_w;
      a_q <= addr;
      if (!we_q && !ce_q && we_n) begin
         log_cmd.push_back(dq_q);
         setup <= (dq_q == fslc_pkg::CMD_LOCK_SETUP);
         if (dq_q == fslc_pkg::CMD_CLEAR_STATUS) stat <= 8'h80;
         else if (setup && (dq_q == fslc_pkg::CMD_LOCK_BLOCK
                  || dq_q == fslc_pkg::CMD_LOCK_MASTER)) begin
            busy <= busy_len;
            last_addr <= a_q;
            stat[7] <= 1'b0;
         end
         else if (setup) stat[5:4] <= 2'b11;
      end
      else if (busy == 1) stat <= 8'h80 | stat | fail_bits;
      if (busy != 0) busy <= busy - 1;
   end
   // Status always readable; junk below bit 7 while busy, bit 0 never stable
   assign dq_r = (!ce_n && !oe_n) ? ((busy != 0) ? {1'b0, tog[6:0]}
                                                : {stat[7:1], tog[0]}) : tog;
   assign rb_n = (busy == 0);
endmodule : fslc_flash_model

// *** sim/flash_status_and_lock_bit_control_tb_top.sv ***
module flash_status_and_lock_bit_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CORE_CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic [2:0]  HSIZE = 3'h2;
   logic [7:0]  fail_bits = 8'h00, busy_len = 8'h01;
   logic [31:0] HRDATA;
   logic        HREADYOUT, HRESP, FL_DQ_OE_N, FL_CE_N, FL_OE_N, FL_WE_N;
   logic        RESET_POWERDOWN_N_PIN, READY_BUSY_N_PIN;
   logic [20:0] FL_ADDR;
   logic [7:0]  FL_DQ_OUT, FL_DQ_IN, dev_dq;
   int          n_mismatch = 0, comparisons = 0;
   // Wire level: the host's byte wins while its enable is low
   assign FL_DQ_IN = !FL_DQ_OE_N ? FL_DQ_OUT : dev_dq;
   fslc_host DUT (.CORE_CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
      .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .FL_ADDR, .FL_DQ_IN, .FL_DQ_OUT,
      .FL_DQ_OE_N, .FL_CE_N, .FL_OE_N, .FL_WE_N, .RESET_POWERDOWN_N_PIN, .READY_BUSY_N_PIN);
   fslc_flash_model M (.clk(CORE_CLK), .addr(FL_ADDR), .dq_w(FL_DQ_OUT), .ce_n(FL_CE_N),
      .oe_n(FL_OE_N), .we_n(FL_WE_N), .fail_bits, .busy_len, .dq_r(dev_dq),
      .rb_n(READY_BUSY_N_PIN));
   initial forever #20 CORE_CLK = ~CORE_CLK;
   task automatic give_verdict;
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   // Watchdog: each sequence needs well under a thousand cycles
   initial begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Hready is read right after the edge, before that edge's updates land
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= {24'h0, a};
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
      chk("hresp", 32'h0, {31'h0, HRESP});
   endtask : ahb
   // Full status order: supply, protect, both, lock set, erase
   function automatic logic [2:0] exp_res(input logic [7:0] s);
      if (s[3]) return 3'(fslc_pkg::RES_SUPPLY);
      if (s[1]) return 3'(fslc_pkg::RES_PROTECT);
      if (s[5] && s[4]) return 3'(fslc_pkg::RES_SEQUENCE);
      if (s[4]) return 3'(fslc_pkg::RES_LOCKSET);
      if (s[5]) return 3'(fslc_pkg::RES_ERASE);
      return 3'(fslc_pkg::RES_OK);
   endfunction : exp_res
   initial begin
      logic [31:0] q, ad;
      logic [7:0]  es, acc, tbl[6];
      logic        m, c, a;
      fslc_pkg::fslc_byte_t ex[$];
      tbl = '{8'h00, 8'h08, 8'h02, 8'h30, 8'h10, 8'h20};
      acc = 8'h00;
      q = $urandom(67913);
      repeat (3) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      ahb(0, fslc_pkg::OFS_CTRL, 0, q); chk("ctrl reset", 32'h10, q);
      ahb(0, fslc_pkg::OFS_STAT, 0, q); chk("stat reset", 32'h4, q);
      ahb(0, 8'h0c, 0, q); chk("unmapped", 32'h0, q);
      ahb(1, 8'h0c, 32'hffffffff, q);
      ahb(0, 8'h0c, 0, q); chk("unmapped wr", 32'h0, q);
      ahb(1, fslc_pkg::OFS_CTRL, 32'h0e, q);
      // A byte-sized write must be ignored, so the readback keeps 0x0e
      HSIZE <= 3'h0;
      ahb(1, fslc_pkg::OFS_CTRL, 32'h10, q);
      HSIZE <= 3'h2;
      ahb(0, fslc_pkg::OFS_CTRL, 0, q); chk("ctrl rb", 32'h0e, q);
      chk("rp pin", 1'b0, RESET_POWERDOWN_N_PIN);
      for (int i = 0; i < 14; i++) begin
         es = tbl[(i < 6) ? i : $urandom % 6];
         m = 1'($urandom);
         c = (i < 6) ? 1'b1 : 1'($urandom);
         a = 1'($urandom);
         ad = $urandom & 32'h1fffff;
         fail_bits <= es;
         busy_len <= 8'($urandom_range(1, 60));
         M.log_cmd.delete();
         ahb(1, fslc_pkg::OFS_ADDR, ad, q);
         ahb(1, fslc_pkg::OFS_CTRL, {27'h0, 1'b1, a, c, m, 1'b1}, q);
         do ahb(0, fslc_pkg::OFS_STAT, 0, q); while (q[1] !== 1'b1);
         es = es | acc | 8'h80;
         chk("stat", {16'h0, es & 8'hfe, 1'b0, exp_res(es), 4'b0110}, q);
         chk("rp pin", 1'b1, RESET_POWERDOWN_N_PIN);
         chk("confirm addr", ad, {11'h0, M.last_addr});
         ex = '{fslc_pkg::CMD_LOCK_SETUP};
         ex.push_back(m ? fslc_pkg::CMD_LOCK_MASTER : fslc_pkg::CMD_LOCK_BLOCK);
         if (c && exp_res(es) != 0) ex.push_back(fslc_pkg::CMD_CLEAR_STATUS);
         if (a) ex.push_back(fslc_pkg::CMD_READ_ARRAY);
         chk("cmd count", ex.size(), M.log_cmd.size());
         foreach (ex[j]) if (j < M.log_cmd.size()) chk("cmd", ex[j], M.log_cmd[j]);
         acc = (c && exp_res(es) != 0) ? 8'h00 : (es & 8'h3a);
      end
      give_verdict();
   end
endmodule : flash_status_and_lock_bit_control_tb_top
